// ==== hdl/vliw_pkg.sv ====
// constants and types shared by the core and its operation slots
// Overview of operation
// - 128 registers of 32 bits, any operand role
// - entry zero always reads zero
// - entry one always reads one
// - other 126 entries are plain storage
// - status, two jump targets, 64-bit tally
// - status word resets to 0x800
// - interrupted taken branch loads interrupted target
// - uninterrupted taken branch loads committed target
// - tally counts clock cycles since reset
// - one five-slot instruction issued per cycle
// - operation acts only when guard true
// - add result usable next cycle, not same
// - load result usable three cycles later
// - taken branch has three delay slots
// - jump-if-false needs true guard, false condition
// - load reads word at base plus displacement
// - over five write-backs sets overflow flag
// - count-stalls bit selects tally stall behaviour
package vliw_pkg;
  localparam int NUM_SLOTS = 5;
  localparam int NUM_REGS  = 128;
  localparam int IDX_W     = 7;
  localparam int DISP_W    = 16;
  typedef enum logic [1:0] {OP_NOP, OP_ADD, OP_LOAD, OP_JMPF} op_e;
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_INT_JT   = 8'h04;
  localparam logic [7:0] OFF_COM_JT   = 8'h08;
  localparam logic [7:0] OFF_TALLY_LO = 8'h0C;
  localparam logic [7:0] OFF_TALLY_HI = 8'h10;
  localparam logic [7:0] OFF_PC       = 8'h14;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0800;
  localparam int          CS_BIT       = 11;
  localparam int          WBE_BIT      = 12;
  localparam logic [31:0] PC_RESET     = 32'h0000_0000;
  localparam logic [31:0] INSTR_STEP   = 32'h0000_0004;
  localparam logic [31:0] CONST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] CONST_ONE    = 32'h0000_0001;
  localparam logic [1:0]  BRANCH_DELAY = 2'h3;
  localparam logic [3:0]  MAX_WB       = 4'h5;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : vliw_pkg

// ==== hdl/op_slot.sv ====
// one operation slot: guard test, adder, load address, jump test
`timescale 1ns/10ps
module op_slot (
  // decoded operation and operand values
  input  wire vliw_pkg::op_e     op,
  input  wire logic [31:0]       guardVal,
  input  wire logic [31:0]       aVal,
  input  wire logic [31:0]       bVal,
  input  wire logic [15:0]       disp,
  // results
  output logic                   fire,
  output logic [31:0]            addSum,
  output logic [31:0]            ldAddr,
  output logic                   jumpTaken
);
  always_comb begin
    fire      = guardVal[0] && (op != vliw_pkg::OP_NOP);
    addSum    = aVal + bVal;
    ldAddr    = aVal + {{16{disp[15]}}, disp};
    jumpTaken = fire && (op == vliw_pkg::OP_JMPF) && !aVal[0];
  end
endmodule : op_slot

// ==== hdl/vliw_core.sv ====
// register file, issue model and special registers of the core
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module vliw_core (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // instruction issue
  input  wire logic                  instValid,
  input  wire logic                  stall,
  input  wire vliw_pkg::op_e [4:0]   instOp,
  input  wire logic [4:0][6:0]       instGuard,
  input  wire logic [4:0][6:0]       instSrcA,
  input  wire logic [4:0][6:0]       instSrcB,
  input  wire logic [4:0][6:0]       instDest,
  input  wire logic [4:0][15:0]      instDisp,
  input  wire logic                  jumpIntr,
  output logic [31:0]                fetchPc,
  // data memory read ports, data one cycle after request
  output logic [4:0]                 ldReq,
  output logic [4:0][31:0]           ldAddr,
  input  wire logic [4:0][31:0]      ldData,
  // AXI4-Lite slave
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [7:0]            awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [7:0]            araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp
);
  logic [31:0]       regFile [vliw_pkg::NUM_REGS];
  logic [31:0]       statusReg;
  logic [31:0]       intJtReg;
  logic [31:0]       comJtReg;
  logic [63:0]       tallyReg;
  logic [31:0]       pendTgtReg;
  logic [1:0]        delayReg;
  logic [4:0][6:0]   ld1DestReg;
  logic [4:0]        ld2ValidReg;
  logic [4:0][6:0]   ld2DestReg;
  logic              awHeldReg;
  logic              wHeldReg;
  logic [7:0]        awAddrReg;
  logic [31:0]       wDataReg;
  logic [3:0]        wStrbReg;
  logic [4:0][31:0]  gVal;
  logic [4:0][31:0]  aVal;
  logic [4:0][31:0]  bVal;
  logic [4:0]        fire;
  logic [4:0][31:0]  sum;
  logic [4:0][31:0]  addr;
  logic [4:0]        jmp;
  logic [4:0]        addWr;
  logic              issue;
  logic              jmpHit;
  logic [31:0]       jmpTgt;
  logic              transfer;
  logic [3:0]        wbCnt;
  logic              wrEn;
  logic [31:0]       rdMux;
  logic              rdHit;
  logic              wrHit;

  // constants are decoded on read, so a stray write cannot disturb them
  function automatic logic [31:0] rd(input logic [6:0] idx);
    if (idx == 7'h00) begin
      return vliw_pkg::CONST_ZERO;
    end
    if (idx == 7'h01) begin
      return vliw_pkg::CONST_ONE;
    end
    return regFile[idx];
  endfunction : rd

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nv[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign issue = instValid && !stall;

  always_comb begin
    for (int s = 0; s < vliw_pkg::NUM_SLOTS; s++) begin
      gVal[s] = rd(instGuard[s]);
      aVal[s] = rd(instSrcA[s]);
      bVal[s] = rd(instSrcB[s]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < vliw_pkg::NUM_SLOTS; g++) begin : gSlot
      op_slot uSlot (
        .op        (instOp[g]),
        .guardVal  (gVal[g]),
        .aVal      (aVal[g]),
        .bVal      (bVal[g]),
        .disp      (instDisp[g]),
        .fire      (fire[g]),
        .addSum    (sum[g]),
        .ldAddr    (addr[g]),
        .jumpTaken (jmp[g])
      );
    end
  endgenerate

  // write-back count and branch pick; lowest taken slot wins
  always_comb begin
    wbCnt  = 4'h0;
    jmpHit = 1'b0;
    jmpTgt = vliw_pkg::CONST_ZERO;
    for (int s = vliw_pkg::NUM_SLOTS - 1; s >= 0; s--) begin
      addWr[s] = issue && fire[s] && (instOp[s] == vliw_pkg::OP_ADD);
      wbCnt = wbCnt + {3'h0, addWr[s]} + {3'h0, ld2ValidReg[s]};
      if (issue && jmp[s]) begin
        jmpHit = 1'b1;
        jmpTgt = bVal[s];
      end
    end
  end

  // adds land at this edge, so same-cycle readers see the old value
  always_ff @(posedge clk) begin
    for (int s = 0; s < vliw_pkg::NUM_SLOTS; s++) begin
      if (addWr[s] && instDest[s] > 7'h01) begin
        regFile[instDest[s]] <= sum[s];
      end
    end
    for (int s = 0; s < vliw_pkg::NUM_SLOTS; s++) begin
      if (ld2ValidReg[s] && ld2DestReg[s] > 7'h01) begin
        regFile[ld2DestReg[s]] <= ldData[s];
      end
    end
  end

  // load pipe: request, then write-back while memory data stands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ldReq       <= 5'h00;
      ldAddr      <= '0;
      ld1DestReg  <= '0;
      ld2ValidReg <= 5'h00;
      ld2DestReg  <= '0;
    end else begin
      for (int s = 0; s < vliw_pkg::NUM_SLOTS; s++) begin
        ldReq[s] <= issue && fire[s] && (instOp[s] == vliw_pkg::OP_LOAD);
      end
      ldAddr      <= addr;
      ld1DestReg  <= instDest;
      ld2ValidReg <= ldReq;
      ld2DestReg  <= ld1DestReg;
    end
  end

  // branches inside the delay shadow are not recognised
  assign transfer = issue && (delayReg == 2'h1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delayReg   <= 2'h0;
      pendTgtReg <= vliw_pkg::PC_RESET;
    end else if (issue) begin
      if (delayReg != 2'h0) begin
        delayReg <= delayReg - 2'h1;
      end else if (jmpHit) begin
        delayReg   <= vliw_pkg::BRANCH_DELAY;
        pendTgtReg <= jmpTgt;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetchPc <= vliw_pkg::PC_RESET;
    end else if (transfer) begin
      fetchPc <= pendTgtReg;
    end else if (issue) begin
      fetchPc <= fetchPc + vliw_pkg::INSTR_STEP;
    end
  end

  // software write to a jump target beats the hardware capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intJtReg <= vliw_pkg::CONST_ZERO;
    end else if (wrEn && awAddrReg == vliw_pkg::OFF_INT_JT) begin
      intJtReg <= merge(intJtReg, wDataReg, wStrbReg);
    end else if (transfer && jumpIntr) begin
      intJtReg <= pendTgtReg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comJtReg <= vliw_pkg::CONST_ZERO;
    end else if (wrEn && awAddrReg == vliw_pkg::OFF_COM_JT) begin
      comJtReg <= merge(comJtReg, wDataReg, wStrbReg);
    end else if (transfer && !jumpIntr) begin
      comJtReg <= pendTgtReg;
    end
  end

  // hardware flag set wins over a coinciding software write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      statusReg <= vliw_pkg::STATUS_RESET;
    end else begin
      if (wrEn && awAddrReg == vliw_pkg::OFF_STATUS) begin
        statusReg <= merge(statusReg, wDataReg, wStrbReg);
      end
      if (wbCnt > vliw_pkg::MAX_WB) begin
        statusReg[vliw_pkg::WBE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tallyReg <= 64'h0000_0000_0000_0000;
    end else if (statusReg[vliw_pkg::CS_BIT] || !stall) begin
      tallyReg <= tallyReg + 64'h0000_0000_0000_0001;
    end
  end

  // AXI4-Lite write: address and data taken in any order
  assign wrEn = awHeldReg && wHeldReg && !bvalid;

  always_comb begin
    wrHit = (awAddrReg == vliw_pkg::OFF_STATUS) || (awAddrReg == vliw_pkg::OFF_INT_JT)
         || (awAddrReg == vliw_pkg::OFF_COM_JT);
    rdHit = 1'b1;
    case (araddr)
      vliw_pkg::OFF_STATUS:   rdMux = statusReg;
      vliw_pkg::OFF_INT_JT:   rdMux = intJtReg;
      vliw_pkg::OFF_COM_JT:   rdMux = comJtReg;
      vliw_pkg::OFF_TALLY_LO: rdMux = tallyReg[31:0];
      vliw_pkg::OFF_TALLY_HI: rdMux = tallyReg[63:32];
      vliw_pkg::OFF_PC:       rdMux = fetchPc;
      default: begin
        rdMux = vliw_pkg::CONST_ZERO;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      awHeldReg <= 1'b0;
      wHeldReg  <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= vliw_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        awHeldReg <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        wHeldReg <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
      if (wrEn) begin
        awHeldReg <= 1'b0;
        wHeldReg  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wrHit ? vliw_pkg::RESP_OKAY : vliw_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= vliw_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdHit ? vliw_pkg::RESP_OKAY : vliw_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence sLoadIssue;
    issue && fire[0] && instOp[0] == vliw_pkg::OP_LOAD && instDest[0] > 7'h01
      && !addWr[0] && !addWr[1] && !addWr[2] && !addWr[3] && !addWr[4];
  endsequence

  sequence sBranchShadow;
    issue && jmpHit && delayReg == 2'h0 ##1 delayReg == 2'h3;
  endsequence

  AST_ZERO_READ: assert property (instSrcA[0] == 7'h00 |-> aVal[0] == 32'h0000_0000)
    else $error("entry zero read nonzero");
  AST_ONE_GUARD: assert property (instGuard[0] == 7'h01 && instOp[0] != vliw_pkg::OP_NOP
    |-> fire[0])
    else $error("constant one not a true guard");
  AST_ADD_NEXT: assert property (addWr[0] && instDest[0] > 7'h01 && ld2ValidReg == 5'h00
    && !addWr[1] && !addWr[2] && !addWr[3] && !addWr[4]
    |=> regFile[$past(instDest[0])] == $past(sum[0]))
    else $error("add result not visible next cycle");
  AST_LOAD_LAT: assert property (sLoadIssue ##1 ldReq[0] ##1 ld2ValidReg[0]
    |=> regFile[$past(ld2DestReg[0])] == $past(ldData[0]))
    else $error("load result not written back");
  AST_LOAD_REQ: assert property (sLoadIssue |=> ldReq[0] && ldAddr[0] == $past(addr[0]))
    else $error("load request address wrong");
  AST_BRANCH_SLOTS: assert property (sBranchShadow
    |-> fetchPc == $past(fetchPc) + vliw_pkg::INSTR_STEP)
    else $error("branch transferred before delay slots");
  AST_TRANSFER: assert property (transfer |=> fetchPc == $past(pendTgtReg))
    else $error("branch target not loaded");
  AST_WBE: assert property (wbCnt > 4'h5 |=> statusReg[vliw_pkg::WBE_BIT])
    else $error("write-back overflow not flagged");
  AST_TALLY: assert property (statusReg[vliw_pkg::CS_BIT] || !stall
    |=> tallyReg == $past(tallyReg) + 64'h0000_0000_0000_0001)
    else $error("tally did not advance");
  AST_TALLY_HOLD: assert property (!statusReg[vliw_pkg::CS_BIT] && stall
    |=> $stable(tallyReg))
    else $error("tally advanced on stall");
  AST_COMMIT_JT: assert property (transfer && !jumpIntr && !wrEn
    |=> comJtReg == $past(pendTgtReg) && $stable(intJtReg))
    else $error("committed target not captured");
  AST_INTR_JT: assert property (transfer && jumpIntr && !wrEn
    |=> intJtReg == $past(pendTgtReg) && $stable(comJtReg))
    else $error("interrupted target not captured");
endmodule : vliw_core

// ==== bench/testbench.sv ====
// self-checking bench for the vliw core: issue model, register file, special registers
`timescale 1ns/10ps
module testbench;
  localparam vliw_pkg::op_e NP = vliw_pkg::OP_NOP;
  localparam vliw_pkg::op_e AD = vliw_pkg::OP_ADD;
  localparam vliw_pkg::op_e LD = vliw_pkg::OP_LOAD;
  localparam vliw_pkg::op_e JF = vliw_pkg::OP_JMPF;
  localparam logic [1:0]    OK = vliw_pkg::RESP_OKAY;
  localparam logic [1:0]    ER = vliw_pkg::RESP_SLVERR;
  logic                clk, nrst, instValid, stall, jumpIntr;
  vliw_pkg::op_e [4:0] instOp, opB;
  logic [4:0][6:0]     instGuard, instSrcA, instSrcB, instDest, gB, aB, bB, dB;
  logic [4:0][15:0]    instDisp, xB;
  logic [4:0]          ldReq;
  logic [4:0][31:0]    ldAddr, ldData;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata, fetchPc, pcExp, v, d, e, s;
  logic [31:0]         seed = 32'h0000_e42b;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, r;
  logic [15:0]         d1, d2, d7;
  logic [6:0]          rx;
  int                  fails = 0, nTests = 0, cyc = 0, hsCyc, c;

  vliw_core dut (.clk, .nrst, .instValid, .stall, .instOp, .instGuard, .instSrcA, .instSrcB,
    .instDest, .instDisp, .jumpIntr, .fetchPc, .ldReq, .ldAddr, .ldData, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // aligned displacement so loaded values double as jump targets and even guards
  function automatic logic [15:0] ad();
    logic [31:0] t;
    t = xs();
    return t[15:0] & 16'hfffc;
  endfunction : ad

  function automatic logic [31:0] sx(input logic [15:0] x);
    return {{16{x[15]}}, x};
  endfunction : sx

  // memory contents as a function of address; low bits pass through untouched
  function automatic logic [31:0] mf(input logic [31:0] a);
    return a ^ 32'ha5a5_0000;
  endfunction : mf

  // idle lanes show the inverse so a capture in the wrong cycle never matches
  always @(posedge clk)
    for (int i = 0; i < 5; i++) ldData[i] <= ldReq[i] ? mf(ldAddr[i]) : ~mf(ldAddr[i]);

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nTests++;
    if (got !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic close_out();
    if (fails == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic put(input int i, input vliw_pkg::op_e o, input logic [6:0] g, a, b, t,
                     input logic [15:0] x = 16'h0000);
    opB[i] = o;
    gB[i]  = g;
    aB[i]  = a;
    bB[i]  = b;
    dB[i]  = t;
    xB[i]  = x;
  endtask : put

  // valid stays up between steps; idle is the only place it drops
  task automatic step(input logic st, input logic ji);
    instOp    <= opB;
    instGuard <= gB;
    instSrcA  <= aB;
    instSrcB  <= bB;
    instDest  <= dB;
    instDisp  <= xB;
    stall     <= st;
    jumpIntr  <= ji;
    instValid <= 1'b1;
    @(posedge clk);
    if (!st) pcExp = pcExp + vliw_pkg::INSTR_STEP;
    for (int i = 0; i < 5; i++) put(i, NP, 1, 0, 0, 0);
  endtask : step

  task automatic idle();
    instValid <= 1'b0;
    stall     <= 1'b0;
    jumpIntr  <= 1'b0;
    @(posedge clk);
    chk("fetchPc", pcExp, fetchPc);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic aw, w;
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata  <= dt;
    wstrb  <= 4'hf;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    hsCyc = cyc;
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex,
                    input logic [1:0] er);
    logic [31:0] dt;
    logic [1:0]  rs;
    rd(a, dt, rs);
    chk(nm, ex, dt);
    chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, rs});
  endtask : rc

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    {instValid, stall, jumpIntr, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    instOp = {5{NP}};
    {instGuard, instSrcA, instSrcB, instDest, instDisp} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    nrst = 1'b0;
    pcExp = 32'h0000_0000;
    for (int i = 0; i < 5; i++) put(i, NP, 1, 0, 0, 0);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rc("status", vliw_pkg::OFF_STATUS, vliw_pkg::STATUS_RESET, OK);
    rc("pc", vliw_pkg::OFF_PC, 32'h0000_0000, OK);
    rc("tallyHi", vliw_pkg::OFF_TALLY_HI, 32'h0000_0000, OK);
    rc("unmapped", 8'h18, 32'h0000_0000, ER);
    wr(vliw_pkg::OFF_PC, xs(), ER);
    v = xs();
    wr(vliw_pkg::OFF_INT_JT, v, OK);
    rc("intJt", vliw_pkg::OFF_INT_JT, v, OK);
    // count-stalls set while running, then cleared: first stalled, then running
    for (int m = 0; m < 3; m++) begin
      stall <= (m == 1);
      rd(vliw_pkg::OFF_TALLY_LO, d, r);
      c = hsCyc;
      rd(vliw_pkg::OFF_TALLY_LO, e, r);
      chk("tallyStep", (m == 1) ? 32'h0000_0000 : 32'(hsCyc - c), e - d);
      if (m == 0) wr(vliw_pkg::OFF_STATUS, 32'h0000_0000, OK);
    end
    stall <= 1'b0;
    wr(vliw_pkg::OFF_STATUS, vliw_pkg::STATUS_RESET, OK);
    d1 = ad();
    d2 = ad();
    d7 = ad();
    put(0, LD, 1, 0, 0, 5, d1);
    step(0, 0);
    put(0, LD, 1, 0, 0, 5, d2);
    put(1, LD, 1, 0, 0, 7, d7);
    step(0, 0);
    chk("ldAddr", sx(d1), ldAddr[0]);
    step(0, 0);
    put(0, LD, 1, 5, 0, 30);
    step(0, 0);
    put(0, LD, 1, 5, 0, 30);
    step(0, 0);
    chk("ldEarly", mf(sx(d1)), ldAddr[0]);
    put(0, AD, 1, 5, 7, 6);
    step(0, 0);
    chk("ldLate", mf(sx(d2)), ldAddr[0]);
    s = mf(sx(d2)) + mf(sx(d7));
    put(0, AD, 1, 6, 1, 6);
    put(1, LD, 1, 6, 0, 30);
    put(2, AD, 0, 1, 1, 7);
    put(3, AD, 5, 1, 1, 7);
    step(0, 0);
    put(0, LD, 1, 6, 0, 30);
    put(1, LD, 1, 7, 0, 31);
    step(0, 0);
    chk("addSame", s, ldAddr[1]);
    put(0, LD, 1, 0, 0, 30);
    put(1, LD, 1, 1, 0, 31);
    step(0, 0);
    chk("addNext", s + 32'h0000_0001, ldAddr[0]);
    chk("guardOff", mf(sx(d7)), ldAddr[1]);
    step(1, 0);
    chk("zeroReg", 32'h0000_0000, ldAddr[0]);
    chk("oneReg", 32'h0000_0001, ldAddr[1]);
    idle();
    for (int k = 0; k < 8; k++) begin
      v = xs();
      rx = 7'(32'h0000_0002 + v % 32'h0000_007e);
      d1 = ad();
      put(0, LD, 1, 0, 0, rx, d1);
      repeat (3) step(0, 0);
      put(0, LD, 1, rx, 0, 30, v[31:16]);
      repeat (2) step(0, 0);
      chk("regRand", mf(sx(d1)) + sx(v[31:16]), ldAddr[0]);
    end
    idle();
    // five write-backs are legal, six must flag
    for (int n = 3; n < 5; n++) begin
      put(0, LD, 1, 0, 0, 20);
      put(1, LD, 1, 0, 0, 21);
      repeat (2) step(0, 0);
      for (int i = 0; i < n; i++) put(i, AD, 1, 1, 1, 7'(22 + i));
      step(0, 0);
      idle();
      e = (n == 4) ? (32'h0000_0001 << vliw_pkg::WBE_BIT) : 32'h0000_0000;
      rc("wbFlag", vliw_pkg::OFF_STATUS, vliw_pkg::STATUS_RESET | e, OK);
    end
    wr(vliw_pkg::OFF_STATUS, vliw_pkg::STATUS_RESET, OK);
    d1 = ad();
    d2 = ad();
    put(0, LD, 1, 0, 0, 8, d1);
    put(1, LD, 1, 0, 0, 9, d2);
    repeat (3) step(0, 0);
    put(0, JF, 0, 0, 8, 0);
    put(1, JF, 1, 1, 8, 0);
    repeat (4) step(0, 0);
    idle();
    for (int j = 0; j < 2; j++) begin
      put(0, JF, 1, 0, 7'(8 + j), 0);
      step(0, 0);
      put(0, AD, 1, 1, 1, 10);
      repeat (2) step(0, 0);
      step(0, j[0]);
      pcExp = mf(sx(j ? d2 : d1));
      idle();
    end
    rc("intJt", vliw_pkg::OFF_INT_JT, mf(sx(d2)), OK);
    rc("comJt", vliw_pkg::OFF_COM_JT, mf(sx(d1)), OK);
    put(0, LD, 1, 10, 0, 30);
    step(0, 0);
    idle();
    chk("delaySlot", 32'h0000_0002, ldAddr[0]);
    close_out();
  end
endmodule : testbench
